/* hw/serial_port.sv */
// Purpose: four-mode serial port (shift register, 8-bit and 9-bit async)
// Assumes: clk is the oscillator; timer overflow pulses come from this clock
// Notes: rxd is a two-way pin split into in/out/enable

`timescale 1ns/10ps
`default_nettype none

// Contract
// - shift mode moves 8 bits LSB first
// - shift mode rate osc/12 or osc/6
// - buffer write loads marker, send follows
// - shift clock low S3-S5, shift at STATE6_PHASE2
// - zeros in, marker ends, flag at STATE1_PHASE1
// - receive starts, loads 11111110 at STATE6_PHASE2
// - clock toggles S3P1/S6P1, sample at S5P2
// - zero at left, final shift, flag set
// - 8-bit frame, stop bit stored
// - fixed 9-bit rate from oscillator divide
// - variable rate from timer 1 or 2
// - async transmit waits for counter rollover
// - start bit, then data, then shifts
// - 8-bit transmit ends at tenth rollover
// - ninth bit loaded, stop inserted, eleventh rollover
// - falling edge starts receive, load 1FFH
// - majority of samples seven, eight, nine
// - nonzero start bit restarts hunting
// - 8-bit accept needs flag clear, stop rule
// - 9-bit accept needs flag clear, ninth rule
// - 9-bit receiver hunts one bit later
// - 9-bit frame, ninth bit stored
// - receive enable only software written
module serial_port
   import serial_port_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] addr,
   input wire logic [7:0] wrData,
   input wire logic wrEn,
   input wire logic rdEn,
   output logic [7:0] rdData,
   input wire logic timer1Ovf,
   input wire logic timer2Ovf,
   input wire logic rxdIn,
   output logic rxdOut,
   output logic rxdOe,
   output logic txd
);
   function automatic logic atPhase(input logic [3:0] ph, input logic [3:0] p,
                                    input logic six);
      atPhase = six ? (ph[3:1] == p[3:1]) : (ph == p);
   endfunction

   function automatic logic [7:0] rev8(input logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         rev8[i] = v[7 - i];
      end
   endfunction

   // ***************
   // registers
   // ***************
   logic [1:0] mode_r;
   logic mpe_r, ren_r, tb8_r, rb8_r, ti_r, ri_r;
   logic six_r, dbl_r, t2sel_r;
   logic [7:0] rxBuf_r, rdData_r;
   logic [3:0] ph_r, ph_nxt;
   logic [2:0] pre_r;
   logic half_r;
   logic rxS1_r, rxS2_r, rxLast_r;
   logic [1:0] smp_r;
   logic m0Smp_r;
   logic [8:0] txShift_r;
   logic txReq_r, txGo_r, send_r, dataOn_r, firstShift_r, txEnd_r;
   logic [3:0] txCnt_r, rxCnt_r;
   logic [8:0] rxShift_r;
   rxState_t rxState_r;
   logic m0Rx_r, m0RxDone_r;
   logic txd_r, rxdOut_r, rxdOe_r;

   // ***************
   // decode and timing
   // ***************
   wire ctrlWr = wrEn && (addr == ADDR_CTRL);
   wire bufWr = wrEn && (addr == ADDR_BUF);
   wire cfgWr = wrEn && (addr == ADDR_CFG);
   wire modeShift = (mode_r == MODE_SHIFT);
   wire mode8 = (mode_r == MODE_ASYNC8);
   wire nine = (mode_r == MODE_FIXED9) || (mode_r == MODE_VAR9);
   // 6-clock operation steps two phases per clock: half the machine cycle
   wire [3:0] phStep = six_r ? PH_STEP6 : PH_STEP12;
   wire [3:0] phSum = ph_r + phStep;
   assign ph_nxt = (phSum > PH_STATE6_PHASE2) ? PH_STATE1_PHASE1 : phSum;
   wire atS1P1 = atPhase(ph_r, PH_STATE1_PHASE1, six_r);
   wire atS5P2 = atPhase(ph_r, PH_S5P2, six_r);
   wire atS6P2 = atPhase(ph_r, PH_STATE6_PHASE2, six_r);
   wire clkLowPh = (ph_r >= PH_S3P1) && (ph_r < PH_S6P1);
   // fixed 9-bit mode: 16x tick every 4, 2 or 1 clocks
   wire [1:0] shAmt = {1'b0, dbl_r} + {1'b0, six_r};
   wire [2:0] m2Period = MODE2_PRE >> shAmt;
   wire preHit = (pre_r == (m2Period - 3'h1));
   // timer 1 overflow is halved unless the baud doubler is set
   wire tmTick = t2sel_r ? timer2Ovf : (timer1Ovf && (dbl_r || half_r));
   wire tick16 = (mode_r == MODE_FIXED9) ? preHit : tmTick;
   wire txRoll = tick16 && (txCnt_r == CNT_LAST) && !modeShift;
   wire fall = tick16 && rxLast_r && !rxS2_r;

   // ***************
   // receive decisions
   // ***************
   wire maj = (smp_r[0] & smp_r[1]) | (smp_r[0] & rxS2_r) | (smp_r[1] & rxS2_r);
   wire bitDone = (rxState_r == RX_RUN) && tick16 && (rxCnt_r == SMP_C);
   wire firstBit = (rxShift_r == RX_ASYNC_INIT);
   wire falseStart = bitDone && firstBit && maj;
   wire rxFinal = bitDone && !firstBit && !rxShift_r[8];
   // same test covers stop bit (8-bit) and ninth bit (9-bit)
   wire rxAccept = rxFinal && !ri_r && (!mpe_r || maj);
   wire hunt = (rxState_r == RX_HUNT) && !modeShift && ren_r && fall;
   wire m0RxStart = modeShift && ren_r && !ri_r && !m0Rx_r && !m0RxDone_r && atS6P2;
   wire m0RxShift = m0Rx_r && !m0RxDone_r && atS6P2;
   wire [7:0] m0RxNext = {rxShift_r[6:0], m0Smp_r};
   wire riSet = rxAccept || (m0RxShift && !rxShift_r[7]);

   // ***************
   // transmit decisions
   // ***************
   wire txMarked = (txShift_r[8:1] == TX_MARK);
   wire m0TxShift = modeShift && send_r && atS6P2;
   wire asShift = !modeShift && send_r && txRoll && dataOn_r;
   wire asDone = asShift && txMarked && (firstShift_r || mode8);
   wire tiSet = (modeShift && txEnd_r && atS1P1) || asDone;
   wire txIns = nine && !firstShift_r;
   wire [8:0] txLoad = {nine ? tb8_r : 1'b1, wrData};

   // ***************
   // software registers
   // ***************
   always_ff @(posedge clk) begin
      if (rst) begin
         {mode_r, mpe_r, ren_r, tb8_r} <= CTRL_RST[7:3];
         {six_r, dbl_r, t2sel_r} <= CFG_RST;
      end else begin
         if (ctrlWr) begin
            mode_r <= wrData[CTRL_MODE_HI:CTRL_MODE_LO];
            mpe_r <= wrData[CTRL_MPE];
            ren_r <= wrData[CTRL_REN];
            tb8_r <= wrData[CTRL_TB8];
         end
         if (cfgWr) begin
            six_r <= wrData[CFG_SIX];
            dbl_r <= wrData[CFG_DBL];
            t2sel_r <= wrData[CFG_T2];
         end
      end
   end

   // hardware set wins over a software clear in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         ti_r <= CTRL_RST[CTRL_TI];
         ri_r <= CTRL_RST[CTRL_RI];
         rb8_r <= CTRL_RST[CTRL_RB8];
      end else begin
         ti_r <= tiSet || (ctrlWr ? wrData[CTRL_TI] : ti_r);
         ri_r <= riSet || (ctrlWr ? wrData[CTRL_RI] : ri_r);
         rb8_r <= rxAccept ? maj : (ctrlWr ? wrData[CTRL_RB8] : rb8_r);
      end
   end

   wire [7:0] ctrlRead = {mode_r, mpe_r, ren_r, tb8_r, rb8_r, ti_r, ri_r};
   wire [7:0] rdNext = !rdEn ? 8'h00 :
                       (addr == ADDR_CTRL) ? ctrlRead :
                       (addr == ADDR_BUF) ? rxBuf_r :
                       (addr == ADDR_CFG) ? {5'h00, t2sel_r, dbl_r, six_r} : 8'h00;

   always_ff @(posedge clk) begin
      if (rst) begin
         rdData_r <= 8'h00;
      end else begin
         rdData_r <= rdNext;
      end
   end

   // ***************
   // timing chain and input sync
   // ***************
   always_ff @(posedge clk) begin
      if (rst) begin
         ph_r <= PH_STATE1_PHASE1;
         pre_r <= 3'h0;
         half_r <= 1'b0;
         rxS1_r <= 1'b1;
         rxS2_r <= 1'b1;
         rxLast_r <= 1'b1;
         m0Smp_r <= 1'b1;
      end else begin
         ph_r <= ph_nxt;
         pre_r <= preHit ? 3'h0 : pre_r + 3'h1;
         half_r <= (timer1Ovf && !t2sel_r) ? !half_r : half_r;
         rxS1_r <= rxdIn;
         rxS2_r <= rxS1_r;
         rxLast_r <= tick16 ? rxS2_r : rxLast_r;
         m0Smp_r <= atS5P2 ? rxS2_r : m0Smp_r;
      end
   end

   // ***************
   // transmitter
   // ***************
   always_ff @(posedge clk) begin
      if (rst) begin
         txShift_r <= 9'h000;
         {txReq_r, txGo_r, send_r, dataOn_r, firstShift_r, txEnd_r} <= 6'h00;
         txCnt_r <= CNT_ZERO;
      end else begin
         txCnt_r <= tick16 ? txCnt_r + 4'h1 : txCnt_r;
         if (bufWr) begin
            txShift_r <= txLoad;
            txReq_r <= 1'b1;
            firstShift_r <= 1'b0;
         end else if (m0TxShift || asShift) begin
            txShift_r <= {txIns, txShift_r[8:1]};
            firstShift_r <= 1'b1;
         end
         if (modeShift) begin
            // up to one machine cycle elapses before send: it waits for the next STATE6_PHASE2
            if (txReq_r && atS6P2 && !send_r && !bufWr) begin
               send_r <= 1'b1;
               txReq_r <= 1'b0;
            end
            if (m0TxShift && txMarked) begin
               txEnd_r <= 1'b1;
            end
            if (txEnd_r && atS1P1) begin
               send_r <= 1'b0;
               txEnd_r <= 1'b0;
            end
         end else begin
            if (txReq_r && txRoll && !bufWr) begin
               txGo_r <= 1'b1;
               txReq_r <= 1'b0;
            end
            if (txGo_r && atS1P1) begin
               send_r <= 1'b1;
               txGo_r <= 1'b0;
            end
            if (send_r && txRoll && !dataOn_r) begin
               dataOn_r <= 1'b1;
            end
            if (asDone) begin
               send_r <= 1'b0;
               dataOn_r <= 1'b0;
            end
         end
      end
   end

   // ***************
   // receiver
   // ***************
   always_ff @(posedge clk) begin
      if (rst) begin
         rxState_r <= RX_HUNT;
         rxCnt_r <= CNT_ZERO;
         rxShift_r <= RX_ASYNC_INIT;
         smp_r <= 2'h3;
         rxBuf_r <= BUF_RST;
         m0Rx_r <= 1'b0;
         m0RxDone_r <= 1'b0;
      end else begin
         if (tick16 && rxCnt_r == SMP_A) begin
            smp_r[0] <= rxS2_r;
         end
         if (tick16 && rxCnt_r == SMP_B) begin
            smp_r[1] <= rxS2_r;
         end
         unique case (rxState_r)
            RX_HUNT: begin
               if (hunt) begin
                  rxCnt_r <= CNT_ZERO;
                  rxShift_r <= RX_ASYNC_INIT;
                  rxState_r <= RX_RUN;
               end
            end
            RX_RUN: begin
               rxCnt_r <= tick16 ? rxCnt_r + 4'h1 : rxCnt_r;
               if (falseStart) begin
                  rxState_r <= RX_HUNT;
               end else if (rxFinal) begin
                  rxState_r <= nine ? RX_TAIL : RX_HUNT;
               end else if (bitDone) begin
                  rxShift_r <= {rxShift_r[7:0], maj};
               end
            end
            RX_TAIL: begin
               rxCnt_r <= tick16 ? rxCnt_r + 4'h1 : rxCnt_r;
               if (bitDone || (tick16 && rxCnt_r == SMP_C)) begin
                  rxState_r <= RX_HUNT;
               end
            end
         endcase
         if (rxAccept) begin
            rxBuf_r <= rev8(rxShift_r[7:0]);
         end
         // shift-mode receiver shares the shift register with async receive
         if (m0RxStart) begin
            rxShift_r[7:0] <= RX_M0_INIT;
            m0Rx_r <= 1'b1;
         end else if (m0RxShift) begin
            rxShift_r[7:0] <= m0RxNext;
            if (!rxShift_r[7]) begin
               rxBuf_r <= rev8(m0RxNext);
               m0RxDone_r <= 1'b1;
            end
         end
         if (m0RxDone_r && atS1P1) begin
            m0Rx_r <= 1'b0;
            m0RxDone_r <= 1'b0;
         end
      end
   end

   // ***************
   // pins
   // ***************
   wire m0Clk = (send_r || m0Rx_r) ? !clkLowPh : 1'b1;
   wire asTx = send_r ? (dataOn_r ? txShift_r[0] : 1'b0) : 1'b1;
   always_ff @(posedge clk) begin
      if (rst) begin
         txd_r <= 1'b1;
         rxdOut_r <= 1'b1;
         rxdOe_r <= 1'b0;
      end else begin
         txd_r <= modeShift ? m0Clk : asTx;
         rxdOut_r <= txShift_r[0];
         rxdOe_r <= modeShift && send_r;
      end
   end

   assign txd = txd_r;
   assign rxdOut = rxdOut_r;
   assign rxdOe = rxdOe_r;
   assign rdData = rdData_r;

   // ***************
   // checks
   // ***************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   false_start_a: assert property (falseStart |=> rxState_r == RX_HUNT)
      else $error("false start not rejected");
   ri_hold_a: assert property (ri_r && !ctrlWr |=> ri_r)
      else $error("receive flag cleared by hardware");
   ti_hold_a: assert property (ti_r && !ctrlWr |=> ti_r)
      else $error("transmit flag cleared by hardware");
   shift_clk_low_a: assert property (modeShift && send_r && clkLowPh |=> !txd_r)
      else $error("shift clock not low in S3-S5");
   m0_rx_load_a: assert property (m0RxStart |=> m0Rx_r && rxShift_r[7:0] == RX_M0_INIT)
      else $error("shift receive not armed");
   async_load_a: assert property (hunt |=> rxShift_r == RX_ASYNC_INIT && rxCnt_r == CNT_ZERO)
      else $error("receive not started on edge");
   full_buf_a: assert property (rxFinal && ri_r |=> $stable(rxBuf_r))
      else $error("frame overwrote unread buffer");
   start_bit_a: assert property (!modeShift && $rose(send_r) |=> !txd_r)
      else $error("start bit not driven");
   stop_insert_a: assert property (nine && asShift && !firstShift_r |=> txShift_r[8])
      else $error("stop bit not inserted");
   ti_async_a: assert property (asDone |=> ti_r && !send_r)
      else $error("transmit end not flagged");

   m0_tx_c: cover property (modeShift && txEnd_r && atS1P1);
   async_rx_c: cover property (rxAccept && mode8);
   nine_rx_c: cover property (rxAccept && nine);
   false_start_c: cover property (falseStart);
endmodule

`default_nettype wire

/* hw/serial_port_pkg.sv */
// Purpose: shared constants for the serial port block
// Assumes: one clock, plain register port with 2-bit word address
// Notes: phase index 0..11 runs state1_phase1 .. state6_phase2

package serial_port_pkg;
   // ***************
   // register map
   // ***************
   localparam logic [1:0] ADDR_CTRL = 2'h0;
   localparam logic [1:0] ADDR_BUF = 2'h1;
   localparam logic [1:0] ADDR_CFG = 2'h2;
   // serial_control_reg fields
   localparam int CTRL_MODE_HI = 7;
   localparam int CTRL_MODE_LO = 6;
   localparam int CTRL_MPE = 5;
   localparam int CTRL_REN = 4;
   localparam int CTRL_TB8 = 3;
   localparam int CTRL_RB8 = 2;
   localparam int CTRL_TI = 1;
   localparam int CTRL_RI = 0;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // configuration fields
   localparam int CFG_SIX = 0;
   localparam int CFG_DBL = 1;
   localparam int CFG_T2 = 2;
   localparam logic [2:0] CFG_RST = 3'h0;
   localparam logic [7:0] BUF_RST = 8'h00;
   // ***************
   // modes
   // ***************
   localparam logic [1:0] MODE_SHIFT = 2'h0;
   localparam logic [1:0] MODE_ASYNC8 = 2'h1;
   localparam logic [1:0] MODE_FIXED9 = 2'h2;
   localparam logic [1:0] MODE_VAR9 = 2'h3;
   // ***************
   // machine cycle and bit timing
   // ***************
   localparam logic [3:0] PH_STATE1_PHASE1 = 4'h0;
   localparam logic [3:0] PH_S3P1 = 4'h4;
   localparam logic [3:0] PH_S5P2 = 4'h9;
   localparam logic [3:0] PH_S6P1 = 4'ha;
   localparam logic [3:0] PH_STATE6_PHASE2 = 4'hb;
   localparam logic [3:0] PH_STEP12 = 4'h1;
   localparam logic [3:0] PH_STEP6 = 4'h2;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_LAST = 4'hf;
   localparam logic [3:0] SMP_A = 4'h7;
   localparam logic [3:0] SMP_B = 4'h8;
   localparam logic [3:0] SMP_C = 4'h9;
   localparam logic [2:0] MODE2_PRE = 3'h4;
   // ***************
   // shift register patterns
   // ***************
   localparam logic [7:0] TX_MARK = 8'h01;
   localparam logic [7:0] RX_M0_INIT = 8'hfe;
   localparam logic [8:0] RX_ASYNC_INIT = 9'h1ff;

   typedef enum logic [1:0] {RX_HUNT, RX_RUN, RX_TAIL} rxState_t;
endpackage

/* test/serial_peer.sv */
// Purpose: remote serial partner for the serial port bench
// Assumes: bit period is given in clk cycles; the receive line has a pull-up
// Notes: behavioural; the bench drives it through its tasks and variables

`timescale 1ns/10ps
`default_nettype none

module serial_peer (
   input wire logic clk,
   input wire logic txd,
   input wire logic rxdOe,
   input wire logic rxdOut,
   output logic line
);
   int period = 16;
   int nBits = 9;
   int gotN = 0;
   int m0Idx = 0;
   int m0Cnt = 0;
   logic mode0 = 1'b0;
   logic m0Arm = 1'b0;
   logic [7:0] m0Byte = 8'h00;
   logic [7:0] m0Sh = 8'h00;
   logic [10:0] fr = 11'h000;
   logic [8:0] v;
   logic [8:0] got = 9'h000;

   // ***************
   // async frames
   // ***************
   initial line = 1'b1;

   // frame bits go out lsb first, start bit included in f
   task automatic send(input logic [10:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         line <= f[i];
         repeat (period) @(posedge clk);
      end
      line <= 1'b1;
   endtask

   task automatic report(input logic [8:0] r);
      got = r;
      gotN++;
   endtask

   // mid-bit sampling; nBits counts the bits after the start bit
   always begin
      @(negedge txd);
      if (!mode0) begin
         repeat (period / 2) @(posedge clk);
         for (int i = 0; i <= nBits; i++) begin
            fr[i] = txd;
            if (i < nBits) repeat (period) @(posedge clk);
         end
         v = {fr[9], fr[8:1]};
         // a bad start or stop is handed back inverted so it cannot match
         report((fr[0] === 1'b0 && fr[nBits] === 1'b1) ? v : ~v);
      end
   end

   // ***************
   // shift register mode
   // ***************
   always @(posedge txd) begin
      if (mode0 && rxdOe === 1'b1) begin
         m0Sh = {rxdOut, m0Sh[7:1]};
         m0Cnt++;
         if (m0Cnt == 8) begin
            m0Cnt = 0;
            report({1'b0, m0Sh});
         end
      end else if (!m0Arm) begin
         line <= 1'b1;
      end
   end

   // new bit at the falling shift clock, held until the next fall; the eighth bit only until the next rise
   always @(negedge txd) begin
      if (mode0 && m0Arm && rxdOe !== 1'b1) begin
         line <= m0Byte[m0Idx];
         m0Idx++;
         m0Arm = (m0Idx < 8);
      end
   end
endmodule

`default_nettype wire

/* test/serial_port_tb_top.sv */
// Purpose: self-checking bench for the four-mode serial port
// Assumes: timer overflows every clk, so async bits are 16 clk long (32 with timer 1 and no doubler)
// Notes: expected values are queued by the driver, popped by the monitor

`timescale 1ns/10ps
`default_nettype none

module serial_port_tb_top
   import serial_port_pkg::*;
;
   logic clk, rst, wrEn, rdEn, timer1Ovf, timer2Ovf, rxdOut, rxdOe, txd, peerLine, chkDly;
   logic [1:0] addr;
   logic [7:0] wrData, rdData, d, c, bufExp;
   wire rxdIn;
   int fail_count = 0;
   int checks = 0;
   int seenN = 0;
   logic [8:0] expQ[$];
   logic [7:0] rxCtl [6] = '{8'h50, 8'h70, 8'h71, 8'hf0, 8'hf0, 8'h90};
   logic rxBit [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
   logic rxAcc [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

   // receive pin: device drive wins, else the partner line
   assign rxdIn = (rxdOe === 1'b1) ? rxdOut : peerLine;

   serial_port i_serial_port(.clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn),
      .rdEn(rdEn), .rdData(rdData), .timer1Ovf(timer1Ovf), .timer2Ovf(timer2Ovf),
      .rxdIn(rxdIn), .rxdOut(rxdOut), .rxdOe(rxdOe), .txd(txd));
   serial_peer i_serial_peer(.clk(clk), .txd(txd), .rxdOe(rxdOe), .rxdOut(rxdOut),
      .line(peerLine));

   // ***************
   // tasks
   // ***************
   task automatic stop_test;
      if (fail_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic cmp(input logic [8:0] v);
      logic [8:0] e;
      checks++;
      if (expQ.size() == 0) e = 9'hxxx;
      else e = expQ.pop_front();
      if (v !== e) begin
         fail_count++;
         $display("mismatch at %0t got %h expected %h", $time, v, e);
      end
   endtask

   // a gap cycle after each strobe keeps one assignment per time step
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      addr <= a;
      wrData <= v;
      wrEn <= 1'b1;
      @(posedge clk);
      wrEn <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      expQ.push_back({1'b0, e});
      addr <= a;
      rdEn <= 1'b1;
      @(posedge clk);
      rdEn <= 1'b0;
      @(posedge clk);
   endtask

   task automatic waitEmpty;
      int n;
      for (n = 0; n < 4000 && expQ.size() > 0; n++) @(posedge clk);
      if (n == 4000) begin
         fail_count++;
         stop_test();
      end
   endtask

   // ***************
   // monitor
   // ***************
   // read data stand for the whole cycle after the strobe: look mid-cycle, off the launch edge
   always @(negedge clk) begin
      if (chkDly === 1'b1) cmp({1'b0, rdData});
      chkDly <= rdEn;
      if (i_serial_peer.gotN != seenN) begin
         seenN = i_serial_peer.gotN;
         cmp(i_serial_peer.got);
      end
   end

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial begin
      repeat (100000) @(posedge clk);
      fail_count++;
      stop_test();
   end

   // ***************
   // main sequence
   // ***************
   initial begin
      rst = 1'b1;
      addr = 2'h0;
      wrData = 8'h00;
      wrEn = 1'b0;
      rdEn = 1'b0;
      chkDly = 1'b0;
      bufExp = BUF_RST;
      timer1Ovf = 1'b1;
      timer2Ovf = 1'b1;
      void'($urandom(63));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(ADDR_CTRL, CTRL_RST);
      rd(2'h3, 8'h00);
      wr(2'h3, 8'hff);
      rd(ADDR_CTRL, CTRL_RST);
      // six-clock, doubler, timer 2: every async mode runs 16 clk per bit
      wr(ADDR_CFG, 8'h07);
      for (int m = 1; m < 4; m++) begin
         for (int tb = 0; tb < 2; tb++) begin
            d = 8'($urandom());
            c = {m[1:0], 2'b00, tb[0], 3'b000};
            i_serial_peer.nBits = (m == 1) ? 9 : 10;
            wr(ADDR_CTRL, c);
            expQ.push_back({(m == 1) ? 1'b1 : tb[0], d});
            wr(ADDR_BUF, d);
            waitEmpty();
            repeat (16) @(posedge clk);
            rd(ADDR_CTRL, c | 8'h02);
         end
      end
      // timer 1 without doubler: overflow halved, 32 clk per bit
      wr(ADDR_CFG, 8'h01);
      i_serial_peer.period = 32;
      i_serial_peer.nBits = 9;
      d = 8'($urandom());
      wr(ADDR_CTRL, 8'h40);
      expQ.push_back({1'b1, d});
      wr(ADDR_BUF, d);
      waitEmpty();
      repeat (32) @(posedge clk);
      rd(ADDR_CTRL, 8'h42);
      i_serial_peer.period = 16;
      wr(ADDR_CFG, 8'h07);
      // a 4-clk low pulse must not pass as a start bit
      wr(ADDR_CTRL, 8'h50);
      i_serial_peer.period = 4;
      i_serial_peer.send(11'h000, 1);
      i_serial_peer.period = 16;
      repeat (48) @(posedge clk);
      rd(ADDR_CTRL, 8'h50);
      for (int k = 0; k < 6; k++) begin
         d = 8'($urandom());
         wr(ADDR_CTRL, rxCtl[k]);
         i_serial_peer.send({1'b1, rxBit[k], d, 1'b0}, (rxCtl[k][7:6] == MODE_ASYNC8) ? 10 : 11);
         repeat (32) @(posedge clk);
         if (rxAcc[k]) bufExp = d;
         rd(ADDR_BUF, bufExp);
         rd(ADDR_CTRL, rxAcc[k] ? ((rxCtl[k] & 8'hfa) | {5'h0, rxBit[k], 2'b01}) : rxCtl[k]);
      end
      // shift register mode at 12 clk per bit
      wr(ADDR_CFG, 8'h00);
      i_serial_peer.mode0 = 1'b1;
      wr(ADDR_CTRL, 8'h00);
      d = 8'($urandom());
      expQ.push_back({1'b0, d});
      wr(ADDR_BUF, d);
      waitEmpty();
      repeat (24) @(posedge clk);
      rd(ADDR_CTRL, 8'h02);
      d = 8'($urandom());
      i_serial_peer.m0Byte = d;
      i_serial_peer.m0Idx = 0;
      i_serial_peer.m0Arm = 1'b1;
      wr(ADDR_CTRL, 8'h10);
      repeat (150) @(posedge clk);
      rd(ADDR_BUF, d);
      rd(ADDR_CTRL, 8'h11);
      stop_test();
   end
endmodule

`default_nettype wire
